// ===== design/crfsp_core.sv
// CPU working register file, result flags and stack pointer
//
// Notes on behaviour
// - Status bit 2 set on negative result
// - Status bit 1 set on zero result
// - Status bit 0 set on carry
// - Four read and write port schemes
// - Register n visible at data address n
// - Registers 26-31 form three pointers
// - Pointers support displacement, increment, decrement
// - Pointers can address any working register
// - Stack grows downward, pointer marks top
// - Push subtracts one, pop adds one
// - Calls subtract two, returns add two
// - High byte bits 2:0 are pointer 10:8
// - Reset loads last SRAM address
// - Stack bytes at I/O 3E/3D, plus 20
// - Read, operate, write back in one cycle
// - Core clock used undivided
// - Fetch overlaps execution, one stage
`timescale 1ns/1ns
`include "crfsp_regs.svh"
module crfsp_core #(
    parameter int SP_WIDTH = 11
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Operand reads
    input wire logic [4:0] rd_a_sel_i,
    input wire logic [4:0] rd_b_sel_i,
    output logic [7:0] rd_a_o,
    output logic [7:0] rd_b_o,
    output logic [15:0] rd_word_o,
    // Result write
    input wire logic wr_en_i,
    input wire logic wr_wide_i,
    input wire logic [4:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    // Flag update from the ALU
    input wire logic flags_we_i,
    input wire logic [7:0] alu_result_i,
    input wire logic alu_carry_i,
    output logic [2:0] flags_o,
    // Pointer addressing
    input wire logic [1:0] ptr_sel_i,
    input wire crfsp_pkg::crfsp_ptr_mode_e ptr_mode_i,
    input wire logic [5:0] ptr_disp_i,
    output logic [15:0] ptr_addr_o,
    // Data space port
    input wire logic ds_rd_i,
    input wire logic ds_wr_i,
    input wire logic [15:0] ds_addr_i,
    input wire logic [7:0] ds_wdata_i,
    output logic [7:0] ds_rdata_o,
    output logic ds_hit_o,
    // I/O port
    input wire logic io_wr_i,
    input wire logic [5:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // Stack
    input wire crfsp_pkg::crfsp_sp_op_e sp_op_i,
    output logic [SP_WIDTH-1:0] sp_o,
    output logic [SP_WIDTH-1:0] stack_addr_o
);
    // Only the 11-bit pointer is built: the high byte carries just three bits
    if (SP_WIDTH != 11) begin : g_bad_sp_width
        $error("crfsp_core: SP_WIDTH must be 11");
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] gpr_q [32];
    logic [7:0] gpr_d [32];
    logic [15:0] ptr_val;
    logic [15:0] ptr_next;
    logic ptr_upd;
    logic [4:0] ptr_low;
    logic ds_gpr;

    always_comb begin
        case (ptr_sel_i)
            2'd0: ptr_low = `CRFSP_PTR_X_LOW;
            2'd1: ptr_low = `CRFSP_PTR_Y_LOW;
            default: ptr_low = `CRFSP_PTR_Z_LOW;
        endcase
        ptr_val = {gpr_q[ptr_low + 5'd1], gpr_q[ptr_low]};
    end

    crfsp_ptr_unit u_ptr (
        .ptr_i(ptr_val),
        .mode_i(ptr_mode_i),
        .disp_i(ptr_disp_i),
        .addr_o(ptr_addr_o),
        .ptr_next_o(ptr_next),
        .update_o(ptr_upd)
    );

    // Data space address n below 0x20 lands on register n, so a pointer can index the file
    assign ds_gpr = (ds_addr_i <= `CRFSP_GPR_LAST_ADDR);

    // Combinational reads: operands are ready in the same cycle the result is written
    always_comb begin
        rd_a_o = gpr_q[rd_a_sel_i];
        rd_b_o = gpr_q[rd_b_sel_i];
        rd_word_o = {gpr_q[{rd_a_sel_i[4:1], 1'b1}], gpr_q[{rd_a_sel_i[4:1], 1'b0}]};
    end

    // Priority: pointer update, then data space store, then ALU result (last wins)
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            gpr_d[i] = gpr_q[i];
        end
        if (ptr_upd) begin
            gpr_d[ptr_low] = ptr_next[7:0];
            gpr_d[ptr_low + 5'd1] = ptr_next[15:8];
        end
        if (ds_wr_i && ds_gpr) begin
            gpr_d[ds_addr_i[4:0]] = ds_wdata_i;
        end
        if (wr_en_i) begin
            if (wr_wide_i) begin
                gpr_d[{wr_sel_i[4:1], 1'b0}] = wr_data_i[7:0];
                gpr_d[{wr_sel_i[4:1], 1'b1}] = wr_data_i[15:8];
            end else begin
                gpr_d[wr_sel_i] = wr_data_i[7:0];
            end
        end
    end

    // Register file holds no reset value; software initialises it
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < 32; i++) begin
            gpr_q[i] <= gpr_d[i];
        end
    end

    // ----------------------------------------
    // Result flags
    // ----------------------------------------
    logic [2:0] flags_q;
    logic [2:0] flags_d;

    always_comb begin
        flags_d = flags_q;
        if (flags_we_i) begin
            flags_d[`CRFSP_STATUS_NEG_BIT] = alu_result_i[7];
            flags_d[`CRFSP_STATUS_ZERO_BIT] = (alu_result_i == 8'h00);
            flags_d[`CRFSP_STATUS_CARRY_BIT] = alu_carry_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

    // ----------------------------------------
    // Stack pointer
    // ----------------------------------------
    logic [SP_WIDTH-1:0] sp_q;
    logic [SP_WIDTH-1:0] sp_d;
    logic [SP_WIDTH-1:0] stack_addr_d;
    logic [SP_WIDTH-1:0] stack_addr_q;
    logic io_spl_wr;
    logic io_sph_wr;

    // I/O and data space views of the same two bytes
    always_comb begin
        io_spl_wr = (io_wr_i && io_addr_i == `CRFSP_IO_SPL) || (ds_wr_i && ds_addr_i == `CRFSP_DS_SPL);
        io_sph_wr = (io_wr_i && io_addr_i == `CRFSP_IO_SPH) || (ds_wr_i && ds_addr_i == `CRFSP_DS_SPH);
    end

    always_comb begin
        sp_d = sp_q;
        stack_addr_d = sp_q;
        case (sp_op_i)
            crfsp_pkg::CRFSP_SP_PUSH1: begin
                stack_addr_d = sp_q;
                sp_d = sp_q - 11'd1;
            end
            crfsp_pkg::CRFSP_SP_POP1: begin
                sp_d = sp_q + 11'd1;
                stack_addr_d = sp_q + 11'd1;
            end
            crfsp_pkg::CRFSP_SP_CALL2: begin
                stack_addr_d = sp_q;
                sp_d = sp_q - 11'd2;
            end
            crfsp_pkg::CRFSP_SP_RET2: begin
                sp_d = sp_q + 11'd2;
                stack_addr_d = sp_q + 11'd1;
            end
            default: begin
                sp_d = sp_q;
            end
        endcase
        // Software writes override a concurrent stack operation
        if (io_spl_wr) begin
            sp_d[7:0] = (io_wr_i && io_addr_i == `CRFSP_IO_SPL) ? io_wdata_i : ds_wdata_i;
        end
        if (io_sph_wr) begin
            sp_d[10:8] = (io_wr_i && io_addr_i == `CRFSP_IO_SPH) ? io_wdata_i[2:0] : ds_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sp_q <= `CRFSP_LAST_SRAM_ADDR;
            stack_addr_q <= `CRFSP_LAST_SRAM_ADDR;
        end else begin
            sp_q <= sp_d;
            stack_addr_q <= stack_addr_d;
        end
    end

    assign sp_o = sp_q;
    assign stack_addr_o = stack_addr_q;

    // ----------------------------------------
    // Read ports for data space and I/O
    // ----------------------------------------
    logic [7:0] ds_rdata_d;
    logic [7:0] ds_rdata_q;
    logic ds_hit_d;
    logic ds_hit_q;
    logic [7:0] io_rdata_d;
    logic [7:0] io_rdata_q;

    always_comb begin
        ds_rdata_d = 8'h00;
        ds_hit_d = 1'b0;
        if (ds_rd_i) begin
            if (ds_gpr) begin
                ds_rdata_d = gpr_q[ds_addr_i[4:0]];
                ds_hit_d = 1'b1;
            end else if (ds_addr_i == `CRFSP_DS_SPL) begin
                ds_rdata_d = sp_q[7:0];
                ds_hit_d = 1'b1;
            end else if (ds_addr_i == `CRFSP_DS_SPH) begin
                ds_rdata_d = {5'h00, sp_q[10:8]};
                ds_hit_d = 1'b1;
            end
        end
        case (io_addr_i)
            `CRFSP_IO_SPL: io_rdata_d = sp_q[7:0];
            `CRFSP_IO_SPH: io_rdata_d = {5'h00, sp_q[10:8]} & `CRFSP_SPH_MASK;
            default: io_rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ds_rdata_q <= 8'h00;
            ds_hit_q <= 1'b0;
            io_rdata_q <= 8'h00;
        end else begin
            ds_rdata_q <= ds_rdata_d;
            ds_hit_q <= ds_hit_d;
            io_rdata_q <= io_rdata_d;
        end
    end

    assign ds_rdata_o = ds_rdata_q;
    assign ds_hit_o = ds_hit_q;
    assign io_rdata_o = io_rdata_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_flag_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        flags_we_i |=> flags_o[1] == ($past(alu_result_i) == 8'h00)) else $error("zero flag wrong");
    a_flag_neg: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        flags_we_i |=> flags_o[2] == $past(alu_result_i[7])) else $error("negative flag wrong");
    a_flag_carry: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        flags_we_i |=> flags_o[0] == $past(alu_carry_i)) else $error("carry flag wrong");
    a_sp_push: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sp_op_i == crfsp_pkg::CRFSP_SP_PUSH1 && !io_spl_wr && !io_sph_wr)
        |=> sp_o == $past(sp_o) - 11'd1) else $error("push did not subtract one");
    a_sp_ret: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sp_op_i == crfsp_pkg::CRFSP_SP_RET2 && !io_spl_wr && !io_sph_wr)
        |=> sp_o == $past(sp_o) + 11'd2) else $error("return did not add two");
    a_sp_reset: assert property (@(posedge clk_sys_i)
        rst_i |=> sp_o == 11'h4ff) else $error("stack pointer reset value wrong");
    a_push_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sp_op_i == crfsp_pkg::CRFSP_SP_PUSH1 |=> stack_addr_o == $past(sp_o)) else $error("push address wrong");
    a_gpr_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_en_i && !wr_wide_i) ##1 (rd_a_sel_i == $past(wr_sel_i))
        |-> rd_a_o == $past(wr_data_i[7:0])) else $error("write back not visible");

    // Second read port and pair write, the other two port schemes
    a_port_b_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_en_i && !wr_wide_i) ##1 (rd_b_sel_i == $past(wr_sel_i))
        |-> rd_b_o == $past(wr_data_i[7:0])) else $error("second operand port stale");
    a_wide_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_en_i && wr_wide_i) ##1 (rd_a_sel_i[4:1] == $past(wr_sel_i[4:1]))
        |-> rd_word_o == $past(wr_data_i)) else $error("pair write not visible");

    // Pointer pairs; a competing store to the file would hide the update
    a_ptr_postinc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ptr_mode_i == crfsp_pkg::CRFSP_PTR_POSTINC && !wr_en_i && !ds_wr_i) ##1 (ptr_sel_i == $past(ptr_sel_i))
        |-> ptr_val == $past(ptr_val) + 16'h0001) else $error("pointer not incremented");
    a_ptr_predec: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ptr_mode_i == crfsp_pkg::CRFSP_PTR_PREDEC
        |-> ptr_addr_o == ptr_val - 16'h0001) else $error("pre decrement address wrong");

    // Stack pointer movement
    a_sp_pop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sp_op_i == crfsp_pkg::CRFSP_SP_POP1 && !io_spl_wr && !io_sph_wr)
        |=> sp_o == $past(sp_o) + 11'd1) else $error("pop did not add one");
    a_sp_call: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sp_op_i == crfsp_pkg::CRFSP_SP_CALL2 && !io_spl_wr && !io_sph_wr)
        |=> sp_o == $past(sp_o) - 11'd2) else $error("call did not subtract two");
    a_sp_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sp_op_i == crfsp_pkg::CRFSP_SP_HOLD && !io_spl_wr && !io_sph_wr)
        |=> $stable(sp_o)) else $error("stack pointer moved while idle");
    a_pop_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sp_op_i == crfsp_pkg::CRFSP_SP_POP1
        |=> stack_addr_o == $past(sp_o) + 11'd1) else $error("pop address wrong");

    // Software writes to the two pointer bytes, then the high byte I/O read; the I/O view wins over a data store
    a_sph_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_wr_i && io_addr_i == `CRFSP_IO_SPH)
        |=> sp_o[10:8] == $past(io_wdata_i[2:0])) else $error("high byte write wrong");
    a_spl_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_wr_i && io_addr_i == `CRFSP_IO_SPL)
        |=> sp_o[7:0] == $past(io_wdata_i)) else $error("low byte write wrong");
    a_ds_spl_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ds_wr_i && ds_addr_i == `CRFSP_DS_SPL && !(io_wr_i && io_addr_i == `CRFSP_IO_SPL))
        |=> sp_o[7:0] == $past(ds_wdata_i)) else $error("low byte data store wrong");
    a_io_sph_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        io_addr_i == `CRFSP_IO_SPH
        |=> io_rdata_o == {5'h00, $past(sp_o[10:8])}) else $error("high byte read wrong");

    // Data space reads: the file answers, anything not held here is refused; flags hold without an update
    a_ds_unmapped: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ds_rd_i && !ds_gpr && ds_addr_i != `CRFSP_DS_SPL && ds_addr_i != `CRFSP_DS_SPH)
        |=> !ds_hit_o && ds_rdata_o == 8'h00) else $error("unmapped read answered");
    a_ds_reg_hit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ds_rd_i && ds_gpr) |=> ds_hit_o) else $error("register read not answered");
    a_flags_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !flags_we_i |=> $stable(flags_o)) else $error("flags changed without an update");
endmodule // crfsp_core

// ===== design/crfsp_regs.svh
// Constants for the CPU register file and stack pointer block
`ifndef CRFSP_REGS_SVH
`define CRFSP_REGS_SVH
`define CRFSP_STATUS_CARRY_BIT 0
`define CRFSP_STATUS_ZERO_BIT 1
`define CRFSP_STATUS_NEG_BIT 2
`define CRFSP_GPR_LAST_ADDR 16'h001f
`define CRFSP_PTR_X_LOW 5'h1a
`define CRFSP_PTR_Y_LOW 5'h1c
`define CRFSP_PTR_Z_LOW 5'h1e
`define CRFSP_IO_SPL 6'h3d
`define CRFSP_IO_SPH 6'h3e
`define CRFSP_DS_SPL 16'h005d
`define CRFSP_DS_SPH 16'h005e
`define CRFSP_SPH_MASK 8'h07
`define CRFSP_LAST_SRAM_ADDR 11'h4ff
`endif

// ===== design/crfsp_pkg.sv
// Types shared by the CPU register file and stack pointer block
package crfsp_pkg;
    typedef enum logic [3:0] {
        CRFSP_PTR_NONE = 4'h1,
        CRFSP_PTR_DISP = 4'h2,
        CRFSP_PTR_POSTINC = 4'h4,
        CRFSP_PTR_PREDEC = 4'h8
    } crfsp_ptr_mode_e;
    typedef enum logic [5:0] {
        CRFSP_SP_HOLD = 6'h01,
        CRFSP_SP_PUSH1 = 6'h02,
        CRFSP_SP_POP1 = 6'h04,
        CRFSP_SP_CALL2 = 6'h08,
        CRFSP_SP_RET2 = 6'h10,
        CRFSP_SP_LOAD = 6'h20
    } crfsp_sp_op_e;
endpackage

// ===== design/crfsp_ptr_unit.sv
// Pointer pair address generator: displacement, post increment, pre decrement
`timescale 1ns/1ns
module crfsp_ptr_unit (
    // Pointer value and mode
    input wire logic [15:0] ptr_i,
    input wire crfsp_pkg::crfsp_ptr_mode_e mode_i,
    input wire logic [5:0] disp_i,
    // Results
    output logic [15:0] addr_o,
    output logic [15:0] ptr_next_o,
    output logic update_o
);
    always_comb begin
        addr_o = ptr_i;
        ptr_next_o = ptr_i;
        update_o = 1'b0;
        case (mode_i)
            crfsp_pkg::CRFSP_PTR_DISP: begin
                addr_o = ptr_i + {10'h000, disp_i};
            end
            crfsp_pkg::CRFSP_PTR_POSTINC: begin
                ptr_next_o = ptr_i + 16'h0001;
                update_o = 1'b1;
            end
            crfsp_pkg::CRFSP_PTR_PREDEC: begin
                addr_o = ptr_i - 16'h0001;
                ptr_next_o = ptr_i - 16'h0001;
                update_o = 1'b1;
            end
            default: begin
                addr_o = ptr_i;
            end
        endcase
    end
endmodule // crfsp_ptr_unit

// ===== test/crfsp_alu_model.sv
// Behavioural adder standing in for the ALU on the far side of the register file
`timescale 1ns/1ns
module crfsp_alu_model (
    // Operands from the register file
    input wire logic [7:0] op_a_i,
    input wire logic [7:0] op_b_i,
    // Result back to the register file
    output logic [7:0] result_o,
    output logic carry_o
);
    // Combinational so the result lands in the same cycle as the operand read
    assign {carry_o, result_o} = {1'b0, op_a_i} + {1'b0, op_b_i};
endmodule // crfsp_alu_model

// ===== test/tb_top.sv
// Self-checking testbench for the register file and stack pointer block
`timescale 1ns/1ns
module tb_top;
    logic clk_sys_i, rst_i, wr_en, wr_wide, flags_we, use_alu, ds_rd, ds_wr, io_wr, ds_hit, carry;
    logic [4:0] rd_a_sel, rd_b_sel, wr_sel;
    logic [7:0] rd_a, rd_b, alu_res, ds_wdata, io_wdata, ds_rdata, io_rdata;
    logic [15:0] rd_word, wr_data, ptr_addr, ds_addr, wr_mux;
    logic [2:0] flags;
    logic [1:0] ptr_sel;
    logic [5:0] ptr_disp, io_addr;
    logic [10:0] sp, stack_addr;
    crfsp_pkg::crfsp_ptr_mode_e ptr_mode;
    crfsp_pkg::crfsp_sp_op_e sp_op;
    int fails, check_count;
    // Write-back takes the ALU result directly so it lands in the operand cycle
    assign wr_mux = use_alu ? {8'h00, alu_res} : wr_data;
    crfsp_alu_model u_crfsp_alu_model (.op_a_i(rd_a), .op_b_i(rd_b), .result_o(alu_res), .carry_o(carry));
    crfsp_core #(.SP_WIDTH(11)) u_crfsp_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rd_a_sel_i(rd_a_sel),
        .rd_b_sel_i(rd_b_sel), .rd_a_o(rd_a), .rd_b_o(rd_b), .rd_word_o(rd_word), .wr_en_i(wr_en),
        .wr_wide_i(wr_wide), .wr_sel_i(wr_sel), .wr_data_i(wr_mux), .flags_we_i(flags_we),
        .alu_result_i(alu_res), .alu_carry_i(carry), .flags_o(flags), .ptr_sel_i(ptr_sel),
        .ptr_mode_i(ptr_mode), .ptr_disp_i(ptr_disp), .ptr_addr_o(ptr_addr), .ds_rd_i(ds_rd),
        .ds_wr_i(ds_wr), .ds_addr_i(ds_addr), .ds_wdata_i(ds_wdata), .ds_rdata_o(ds_rdata),
        .ds_hit_o(ds_hit), .io_wr_i(io_wr), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
        .io_rdata_o(io_rdata), .sp_op_i(sp_op), .sp_o(sp), .stack_addr_o(stack_addr));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] sel, input logic [15:0] d, input logic wide);
        @(posedge clk_sys_i);
        wr_en <= 1'b1; wr_wide <= wide; wr_sel <= sel; wr_data <= d;
        @(posedge clk_sys_i);
        wr_en <= 1'b0;
    endtask
    task automatic ds_read(input logic [15:0] a);
        @(posedge clk_sys_i);
        ds_rd <= 1'b1; ds_addr <= a;
        @(posedge clk_sys_i);
        ds_rd <= 1'b0;
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_alu(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        wr_reg(5'h01, {8'h00, a}, 1'b0);
        wr_reg(5'h02, {8'h00, b}, 1'b0);
        @(posedge clk_sys_i);
        rd_a_sel <= 5'h01; rd_b_sel <= 5'h02; flags_we <= 1'b1; use_alu <= 1'b1;
        wr_en <= 1'b1; wr_wide <= 1'b0; wr_sel <= 5'h03;
        @(posedge clk_sys_i);
        flags_we <= 1'b0; use_alu <= 1'b0; wr_en <= 1'b0; rd_a_sel <= 5'h03;
        rd_b_sel <= 5'h03;
        #1;
        chk({13'h0, flags}, {13'h0, s[7], s[7:0] == 8'h00, s[8]}, "flags");
        chk({8'h00, rd_a}, {8'h00, s[7:0]}, "write back");
        chk({8'h00, rd_b}, {8'h00, s[7:0]}, "write back port b");
        $display("test alu %h %h done", a, b);
    endtask
    task automatic t_map;
        rd_a_sel <= 5'h1a;
        wr_reg(5'h1a, 16'h1234, 1'b1);
        @(posedge clk_sys_i);
        rd_a_sel <= 5'h1a; ds_wr <= 1'b1; ds_addr <= 16'h0004; ds_wdata <= 8'h5a;
        @(posedge clk_sys_i);
        ds_wr <= 1'b0; rd_b_sel <= 5'h04;
        #1;
        chk(rd_word, 16'h1234, "pair word");
        chk({8'h00, rd_b}, 16'h005a, "data store to register");
        ds_read(16'h001b);
        chk({7'h0, ds_hit, ds_rdata}, 16'h0112, "register by data address");
        ds_read(16'h0100);
        chk({7'h0, ds_hit, ds_rdata}, 16'h0000, "unmapped read");
        $display("test map done");
    endtask
    task automatic t_ptr;
        @(posedge clk_sys_i);
        ptr_sel <= 2'h0; ptr_mode <= crfsp_pkg::CRFSP_PTR_DISP; ptr_disp <= 6'h05;
        #1;
        chk(ptr_addr, 16'h1239, "displacement");
        @(posedge clk_sys_i);
        ptr_mode <= crfsp_pkg::CRFSP_PTR_POSTINC;
        #1;
        chk(ptr_addr, 16'h1234, "post increment address");
        @(posedge clk_sys_i);
        ptr_mode <= crfsp_pkg::CRFSP_PTR_PREDEC;
        #1;
        chk(rd_word, 16'h1235, "post increment update");
        chk(ptr_addr, 16'h1234, "pre decrement address");
        @(posedge clk_sys_i);
        ptr_mode <= crfsp_pkg::CRFSP_PTR_NONE;
        #1;
        chk(rd_word, 16'h1234, "pre decrement update");
        $display("test pointer done");
    endtask
    task automatic t_stack;
        crfsp_pkg::crfsp_sp_op_e ops [4];
        logic [10:0] exp_sp [4];
        logic [10:0] exp_sa [4];
        ops = '{crfsp_pkg::CRFSP_SP_PUSH1, crfsp_pkg::CRFSP_SP_CALL2, crfsp_pkg::CRFSP_SP_RET2,
            crfsp_pkg::CRFSP_SP_POP1};
        exp_sp = '{11'h41f, 11'h41d, 11'h41f, 11'h420};
        exp_sa = '{11'h420, 11'h41f, 11'h41e, 11'h420};
        // Software places the stack before any call is issued
        @(posedge clk_sys_i);
        io_wr <= 1'b1; io_addr <= 6'h3d; io_wdata <= 8'h20;
        @(posedge clk_sys_i);
        io_addr <= 6'h3e; io_wdata <= 8'hfc;
        @(posedge clk_sys_i);
        io_wr <= 1'b0;
        #1;
        chk({5'h0, sp}, 16'h0420, "stack pointer bytes");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            sp_op <= (i < 4) ? ops[i] : crfsp_pkg::CRFSP_SP_HOLD;
            if (i > 0) begin
                #1;
                chk({5'h0, sp}, {5'h0, exp_sp[i-1]}, "stack pointer step");
                chk({5'h0, stack_addr}, {5'h0, exp_sa[i-1]}, "stack address");
            end
        end
        ds_read(16'h005e);
        chk({8'h00, ds_rdata}, 16'h0004, "high byte in data space");
        chk({8'h00, io_rdata}, 16'h0004, "high byte in io space");
        // Low byte through the data space store path, read back in both views
        @(posedge clk_sys_i);
        ds_wr <= 1'b1; ds_addr <= 16'h005d; ds_wdata <= 8'h10; io_addr <= 6'h3d;
        @(posedge clk_sys_i);
        ds_wr <= 1'b0;
        #1;
        chk({5'h0, sp}, 16'h0410, "low byte by data store");
        ds_read(16'h005d);
        chk({7'h0, ds_hit, ds_rdata}, 16'h0110, "low byte in data space");
        chk({8'h00, io_rdata}, 16'h0010, "low byte in io space");
        $display("test stack done");
    endtask
    task automatic t_reset;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        chk({5'h0, sp}, 16'h04ff, "reset stack pointer");
        chk({5'h0, stack_addr}, 16'h04ff, "reset stack address");
        chk({13'h0, flags}, 16'h0000, "reset flags");
        $display("test reset done");
    endtask
    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #20000;
        fails++;
        results();
    end
    initial begin
        fails = 0; check_count = 0; rst_i = 1'b1; rd_a_sel = 5'h0; rd_b_sel = 5'h0; wr_en = 1'b0;
        wr_wide = 1'b0; wr_sel = 5'h0; wr_data = 16'h0; flags_we = 1'b0; use_alu = 1'b0; ptr_sel = 2'h0;
        ptr_mode = crfsp_pkg::CRFSP_PTR_NONE; ptr_disp = 6'h0; ds_rd = 1'b0; ds_wr = 1'b0;
        ds_addr = 16'h0; ds_wdata = 8'h0; io_wr = 1'b0; io_addr = 6'h0; io_wdata = 8'h0;
        sp_op = crfsp_pkg::CRFSP_SP_HOLD;
        t_reset();
        t_alu(8'h80, 8'h80);
        t_alu(8'h7f, 8'h01);
        t_alu(8'h05, 8'h03);
        t_map();
        t_ptr();
        t_stack();
        results();
    end
endmodule // tb_top
